// *** src/mip_pkg.sv ***
// Purpose: Shared constants, types and helpers for the metering interrupt,
//          peak record and temperature block.
// Assumes: Core clock of 100 MHz; serial command byte is W,0,A5..A0.
// Notes:   All offsets, field positions, reset values and counts live here.
package mip_pkg;

   // Serial framing
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam int CMD_WRITE_POS = 6;

   // Register offsets on the serial port
   localparam logic [5:0] ADDR_MODE = 6'h09;
   localparam logic [5:0] ADDR_IRQ_EN = 6'h0a;
   localparam logic [5:0] ADDR_FLAGS = 6'h0b;
   localparam logic [5:0] ADDR_FLAGS_RC = 6'h0c;
   localparam logic [5:0] ADDR_CURRENT_PEAK_HOLD = 6'h22;
   localparam logic [5:0] ADDR_CURRENT_PEAK_HOLD_RC = 6'h23;
   localparam logic [5:0] ADDR_VOLTAGE_PEAK_HOLD = 6'h24;
   localparam logic [5:0] ADDR_VOLTAGE_PEAK_HOLD_RC = 6'h25;
   localparam logic [5:0] ADDR_TEMP = 6'h26;

   // Transfer lengths in bits
   localparam logic [5:0] LEN_8 = 6'h08;
   localparam logic [5:0] LEN_16 = 6'h10;
   localparam logic [5:0] LEN_24 = 6'h18;

   // Field positions
   localparam int FLAG_TEMP_DONE = 5;
   localparam int MODE_TEMP_START = 5;

   // Reset values
   localparam logic [15:0] FLAGS_RST = 16'h0000;
   localparam logic [15:0] IRQ_EN_RST = 16'h0000;
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [23:0] PEAK_RST = 24'h000000;
   localparam logic [7:0] TEMP_RST = 8'h00;

   // Modulator and decimation filter
   localparam logic [1:0] QUARTER_LAST = 2'h3;
   localparam logic [4:0] FILT_LAST = 5'h1f;
   localparam logic [5:0] FILT_MID = 6'h10;
   localparam logic [17:0] FILT_PAD = 18'h00000;

   // Temperature conversion timing
   localparam int QUARTER_DIV = 4;
   localparam int TEMP_CONV_US = 26;
   localparam int TEMP_QTICKS = 24;
   localparam int TEMP_CONV_CLKS = TEMP_QTICKS * QUARTER_DIV;
   localparam logic [4:0] TEMP_QLAST = 5'(TEMP_QTICKS - 1);

   // Latched serial command
   typedef struct packed {
      logic write;
      logic [5:0] addr;
   } mip_cmd_s;

   // One filter output word
   typedef struct packed {
      logic valid;
      logic [23:0] value;
   } mip_sample_s;

   typedef enum logic [1:0] {TEMP_IDLE, TEMP_ARMED, TEMP_CONVERT} mip_temp_e;

   // Data length of a register transfer
   function automatic logic [5:0] mip_data_bits(input logic [5:0] addr);
      logic [5:0] len;
      len = LEN_8;
      if (addr == ADDR_MODE || addr == ADDR_IRQ_EN || addr == ADDR_FLAGS ||
          addr == ADDR_FLAGS_RC) begin
         len = LEN_16;
      end else if (addr == ADDR_CURRENT_PEAK_HOLD || addr == ADDR_CURRENT_PEAK_HOLD_RC ||
                   addr == ADDR_VOLTAGE_PEAK_HOLD || addr == ADDR_VOLTAGE_PEAK_HOLD_RC) begin
         len = LEN_24;
      end
      return len;
   endfunction

endpackage

// *** src/mip_irq_peak_temp.sv ***
// Purpose: Interrupt flags and request line, channel peak records and
//          temperature conversion sequencing, reached over a serial port.
// Assumes: Serial port runs on its own clock sclk; din sampled on falling
//          edges, dout changes on rising edges; csN frames each transfer.
// Notes:   Behaviour
// Behaviour
// - Current and voltage peak records are unsigned 24-bit registers.
// - A sample magnitude above the stored record overwrites that record, except current samples during a temperature conversion.
// - Voltage record holds twice the largest voltage sample magnitude.
// - Current record holds the largest current sample magnitude unscaled.
// - Reading a peak clear alias returns the value, then zeroes it.
// - Every interrupt event sets its bit in the 16-bit flag register.
// - Request output goes low while any set flag is enabled.
// - Flags latch whatever the enables say; enables gate the request only.
// - Host reads flags with reset at address 0Ch to find sources.
// - Read with reset releases the request at last command falling edge.
// - Request stays high until the last flag data bit is shifted out.
// - After that transfer request goes low again only if enabled pending.
// - Events during a read with reset are kept and signalled afterwards.
// - Mode bit 5 set arms a temperature conversion for next zero crossing.
// - Zero crossing while armed routes the sensor to the current converter.
// - Temperature written 24 quarter-rate cycles after the zero crossing.
// - Finished conversion with enable bit 5 set drives the request low.
// - Temperature result is a signed two's complement 8-bit value.
// - Modulators are clocked at one quarter of the input clock.
// - Filter averages the modulator bit stream into 24-bit words.
// - Read with reset clears only the flags it reported; request then follows the enabled flags.
// - Interrupt enable register sits at address 0x0A.
`timescale 1ns/10ps
`default_nettype none

module mip_irq_peak_temp (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic sclk,
   input wire logic csN,
   input wire logic din,
   output logic dout,
   output logic irqN,
   input wire logic [1:0] modBits,
   output logic modClk,
   output logic tempSelect,
   input wire logic [15:0] extEvents
);

   // ---------------- Serial clock domain ----------------
   logic frameRst;
   logic [5:0] bitCnt_reg;
   logic [6:0] cmdShift_reg;
   mip_pkg::mip_cmd_s cmd_reg;
   logic [23:0] wrShift_reg;
   logic [23:0] wrData_reg;
   logic cmdTgl_reg;
   logic wrTgl_reg;
   logic doneTgl_reg;
   logic dout_reg;
   logic [23:0] rdWord_reg;

   // Frame decode
   wire logic [5:0] nBits = mip_pkg::mip_data_bits(cmd_reg.addr);
   wire logic cmdEdge = (bitCnt_reg == mip_pkg::CMD_BITS - 6'h01);
   wire logic inData = (bitCnt_reg >= mip_pkg::CMD_BITS);
   wire logic lastEdge = (bitCnt_reg == mip_pkg::CMD_BITS - 6'h01 + nBits);
   wire logic [5:0] dataIdx = bitCnt_reg - mip_pkg::CMD_BITS;
   wire logic [5:0] outIdx = nBits - 6'h01 - dataIdx;
   wire logic [23:0] wrWord = {wrShift_reg[22:0], din};

   // Deselect clears the bit count; a command already latched in a cut frame still acts
   assign frameRst = rst | csN;

   // Falling edges counted within a frame
   always_ff @(negedge sclk or posedge frameRst) begin
      if (frameRst) begin
         bitCnt_reg <= 6'h00;
      end else if (bitCnt_reg != 6'h3f) begin
         bitCnt_reg <= bitCnt_reg + 6'h01;
      end
   end

   // Command and write data capture, event toggles toward the core
   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         cmdShift_reg <= 7'h00;
         cmd_reg <= '0;
         wrShift_reg <= 24'h000000;
         wrData_reg <= 24'h000000;
         cmdTgl_reg <= 1'b0;
         wrTgl_reg <= 1'b0;
         doneTgl_reg <= 1'b0;
      end else if (!csN) begin
         if (!cmdEdge && !inData) begin
            cmdShift_reg <= {cmdShift_reg[5:0], din};
         end
         if (cmdEdge) begin
            cmd_reg.write <= cmdShift_reg[mip_pkg::CMD_WRITE_POS];
            cmd_reg.addr <= {cmdShift_reg[4:0], din};
            wrShift_reg <= 24'h000000;
            cmdTgl_reg <= ~cmdTgl_reg;
         end
         if (inData && cmd_reg.write) begin
            wrShift_reg <= wrWord;
         end
         if (inData && lastEdge && cmd_reg.write) begin
            wrData_reg <= wrWord;
            wrTgl_reg <= ~wrTgl_reg;
         end
         if (inData && lastEdge && !cmd_reg.write) begin
            doneTgl_reg <= ~doneTgl_reg;
         end
      end
   end

   // Read data out, MSB first; rdWord_reg is held stable by the handshake
   always_ff @(posedge sclk or posedge frameRst) begin
      if (frameRst) begin
         dout_reg <= 1'b0;
      end else if (inData && !cmd_reg.write && dataIdx < nBits) begin
         dout_reg <= rdWord_reg[outIdx[4:0]];
      end
   end

   assign dout = dout_reg;

   // ---------------- Core clock domain ----------------
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic [2:0] sync3_reg;
   logic [1:0] modSync1_reg;
   logic [1:0] modSync2_reg;

   // Toggle and pin synchronisers
   // Only the second stage feeds logic; the third gives the toggle edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         sync3_reg <= 3'h0;
         modSync1_reg <= 2'h0;
         modSync2_reg <= 2'h0;
      end else if (ce) begin
         sync1_reg <= {doneTgl_reg, wrTgl_reg, cmdTgl_reg};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         modSync1_reg <= modBits;
         modSync2_reg <= modSync1_reg;
      end
   end

   // Port events and command decode (cmd_reg static after toggle)
   wire logic [2:0] portEvt = sync2_reg ^ sync3_reg;
   wire logic cmdEvt = portEvt[0] & ce;
   wire logic wrEvt = portEvt[1] & ce;
   wire logic doneEvt = portEvt[2] & ce;
   wire logic rdCmd = cmdEvt & ~cmd_reg.write;
   wire logic [5:0] cmdAddr = cmd_reg.addr;
   wire logic flagsRstRd = rdCmd && cmdAddr == mip_pkg::ADDR_FLAGS_RC;
   wire logic rdDone = doneEvt & ~cmd_reg.write;
   wire logic wrMode = wrEvt && cmdAddr == mip_pkg::ADDR_MODE;
   wire logic wrEnable = wrEvt && cmdAddr == mip_pkg::ADDR_IRQ_EN;

   logic [15:0] flags_reg;
   logic [15:0] interrupt_enables_reg;
   logic [15:0] mode_reg;
   logic [23:0] current_peak_hold_reg;
   logic [23:0] voltage_peak_hold_reg;
   logic [7:0] temp_reg;
   logic rstRdActive_reg;
   logic irqN_reg;
   logic [1:0] qCnt_reg;
   logic [4:0] tickCnt_reg;
   logic voltSign_reg;
   mip_pkg::mip_temp_e tempState_reg;
   mip_pkg::mip_temp_e tempState_next;
   logic [4:0] tempCnt_reg;
   logic tempSel_reg;

   // Quarter-rate modulator clock
   wire logic qTick = ce && qCnt_reg == mip_pkg::QUARTER_LAST;
   wire logic filtDump = qTick && tickCnt_reg == mip_pkg::FILT_LAST;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         qCnt_reg <= 2'h0;
         tickCnt_reg <= 5'h00;
      end else if (ce) begin
         qCnt_reg <= qCnt_reg + 2'h1;
         if (qTick) begin
            tickCnt_reg <= tickCnt_reg + 5'h01;
         end
      end
   end

   assign modClk = qCnt_reg[1];

   // Decimation filter per channel: 0 current, 1 voltage
   // Plain ones count over 32 ticks, centred on half scale
   for (genvar ch = 0; ch < 2; ch++) begin : filt
      logic [5:0] ones_reg;
      mip_pkg::mip_sample_s samp_reg;
      wire logic [5:0] onesIncl = ones_reg + {5'h00, modSync2_reg[ch]};
      wire logic [5:0] centred = onesIncl - mip_pkg::FILT_MID;

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            ones_reg <= 6'h00;
            samp_reg <= '0;
         end else if (ce) begin
            samp_reg.valid <= 1'b0;
            if (filtDump) begin
               samp_reg.valid <= 1'b1;
               samp_reg.value <= {centred, mip_pkg::FILT_PAD};
               ones_reg <= 6'h00;
            end else if (qTick) begin
               ones_reg <= onesIncl;
            end
         end
      end
   end

   // Sample magnitudes
   wire mip_pkg::mip_sample_s curSamp = filt[0].samp_reg;
   wire mip_pkg::mip_sample_s voltSamp = filt[1].samp_reg;
   wire logic [23:0] curAbs = curSamp.value[23] ? 24'h000000 - curSamp.value : curSamp.value;
   wire logic [23:0] voltAbs = voltSamp.value[23] ? 24'h000000 - voltSamp.value :
                                 voltSamp.value;
   wire logic [23:0] voltTwice = {voltAbs[22:0], 1'b0};

   // Peak records: clear after read of alias, new larger sample wins
   wire logic ipeakClr = rdDone && cmdAddr == mip_pkg::ADDR_CURRENT_PEAK_HOLD_RC;
   wire logic vpeakClr = rdDone && cmdAddr == mip_pkg::ADDR_VOLTAGE_PEAK_HOLD_RC;
   wire logic [23:0] ipeakBase = ipeakClr ? mip_pkg::PEAK_RST : current_peak_hold_reg;
   wire logic [23:0] vpeakBase = vpeakClr ? mip_pkg::PEAK_RST : voltage_peak_hold_reg;
   // Sensor owns the current converter during conversion: no current peak update
   wire logic ipeakUpd = curSamp.valid && !tempSel_reg && curAbs > ipeakBase;
   wire logic vpeakUpd = voltSamp.valid && voltTwice > vpeakBase;
   wire logic [23:0] current_peak_hold_next = ipeakUpd ? curAbs : ipeakBase;
   wire logic [23:0] voltage_peak_hold_next = vpeakUpd ? voltTwice : vpeakBase;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         current_peak_hold_reg <= mip_pkg::PEAK_RST;
         voltage_peak_hold_reg <= mip_pkg::PEAK_RST;
      end else if (ce) begin
         current_peak_hold_reg <= current_peak_hold_next;
         voltage_peak_hold_reg <= voltage_peak_hold_next;
      end
   end

   // Zero crossing on voltage sample sign change
   wire logic zeroCross = voltSamp.valid && voltSamp.value[23] != voltSign_reg;

   // Temperature sequencer
   wire logic tempFinish = tempState_reg == mip_pkg::TEMP_CONVERT && qTick &&
                           tempCnt_reg == mip_pkg::TEMP_QLAST;

   always_comb begin
      tempState_next = tempState_reg;
      case (tempState_reg)
         mip_pkg::TEMP_IDLE: begin
            if (mode_reg[mip_pkg::MODE_TEMP_START]) begin
               tempState_next = mip_pkg::TEMP_ARMED;
            end
         end
         mip_pkg::TEMP_ARMED: begin
            if (!mode_reg[mip_pkg::MODE_TEMP_START]) begin
               tempState_next = mip_pkg::TEMP_IDLE;
            end else if (zeroCross) begin
               tempState_next = mip_pkg::TEMP_CONVERT;
            end
         end
         mip_pkg::TEMP_CONVERT: begin
            if (tempFinish) begin
               tempState_next = mip_pkg::TEMP_IDLE;
            end
         end
         default: begin
            tempState_next = mip_pkg::TEMP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tempState_reg <= mip_pkg::TEMP_IDLE;
         tempCnt_reg <= 5'h00;
         tempSel_reg <= 1'b0;
         temp_reg <= mip_pkg::TEMP_RST;
         voltSign_reg <= 1'b0;
      end else if (ce) begin
         tempState_reg <= tempState_next;
         if (voltSamp.valid) begin
            voltSign_reg <= voltSamp.value[23];
         end
         if (tempState_next == mip_pkg::TEMP_CONVERT && tempState_reg != tempState_next) begin
            tempCnt_reg <= 5'h00;
            tempSel_reg <= 1'b1;
         end else if (tempState_reg == mip_pkg::TEMP_CONVERT && qTick) begin
            tempCnt_reg <= tempCnt_reg + 5'h01;
         end
         if (tempFinish) begin
            temp_reg <= curAbs[23] ? 8'h00 : curSamp.value[23:16];
            tempSel_reg <= 1'b0;
         end
      end
   end

   assign tempSelect = tempSel_reg;

   // Mode and enable registers; a host write wins over the hardware clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_reg <= mip_pkg::MODE_RST;
         interrupt_enables_reg <= mip_pkg::IRQ_EN_RST;
      end else if (ce) begin
         if (wrMode) begin
            mode_reg <= wrData_reg[15:0];
         end else if (tempFinish) begin
            mode_reg[mip_pkg::MODE_TEMP_START] <= 1'b0;
         end
         if (wrEnable) begin
            interrupt_enables_reg <= wrData_reg[15:0];
         end
      end
   end

   // Flag register: events set, read with reset clears the snapshot
   // An event in the clear cycle survives, so nothing is lost
   wire logic [15:0] tempEvt = {15'h0000, tempFinish} << mip_pkg::FLAG_TEMP_DONE;
   wire logic [15:0] events = extEvents | tempEvt;
   wire logic [15:0] flagClr = flagsRstRd ? flags_reg : 16'h0000;
   wire logic [15:0] flags_next = (flags_reg & ~flagClr) | events;
   wire logic rstRd_next = flagsRstRd | (rstRdActive_reg & ~rdDone);
   wire logic pendEn = |(flags_next & interrupt_enables_reg);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_reg <= mip_pkg::FLAGS_RST;
         rstRdActive_reg <= 1'b0;
         irqN_reg <= 1'b1;
      end else if (ce) begin
         flags_reg <= flags_next;
         rstRdActive_reg <= rstRd_next;
         irqN_reg <= ~(pendEn & ~rstRd_next);
      end
   end

   assign irqN = irqN_reg;

   // Read data selection; plain flag read has no side effect
   wire logic [23:0] rdSel =
      (cmdAddr == mip_pkg::ADDR_MODE) ? {8'h00, mode_reg} :
      (cmdAddr == mip_pkg::ADDR_IRQ_EN) ? {8'h00, interrupt_enables_reg} :
      (cmdAddr == mip_pkg::ADDR_FLAGS) ? {8'h00, flags_reg} :
      (cmdAddr == mip_pkg::ADDR_FLAGS_RC) ? {8'h00, flags_reg} :
      (cmdAddr == mip_pkg::ADDR_CURRENT_PEAK_HOLD || cmdAddr == mip_pkg::ADDR_CURRENT_PEAK_HOLD_RC) ? current_peak_hold_reg :
      (cmdAddr == mip_pkg::ADDR_VOLTAGE_PEAK_HOLD || cmdAddr == mip_pkg::ADDR_VOLTAGE_PEAK_HOLD_RC) ? voltage_peak_hold_reg :
      (cmdAddr == mip_pkg::ADDR_TEMP) ? {16'h0000, temp_reg} : 24'h000000;

   // Read word captured once per read command
   // Same edge as the flag clear, so reported bits are exactly cleared bits
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdWord_reg <= 24'h000000;
      end else if (rdCmd) begin
         rdWord_reg <= rdSel;
      end
   end

endmodule

`default_nettype wire

// *** dv/mip_irq_peak_temp_sva.sv ***
// Purpose: Port-level checks of request line, conversion and modulator clock.
// Assumes: Checks pause while clock enable is low; serial clock far slower than clk.
// Notes: Serial frames are decoded here from sclk, csN and din.
`timescale 1ns/10ps
`default_nettype none
module mip_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic sclk,
   input wire logic csN,
   input wire logic din,
   input wire logic dout,
   input wire logic irqN,
   input wire logic [1:0] modBits,
   input wire logic modClk,
   input wire logic tempSelect,
   input wire logic [15:0] extEvents
);
   logic sPrev, pend;
   logic [4:0] nFall;
   logic [7:0] cmdR, hc, selC;
   logic [23:0] sh;
   logic [15:0] enR;
   // Frame decode
   wire fallE = sPrev && !sclk && !csN;
   wire [7:0] cmdNow = {sh[6:0], din};
   wire cmdDone = fallE && nFall == 5'h07;
   wire rwrDone = cmdDone && cmdNow == 8'h0c;
   wire plainDone = cmdDone && cmdNow == 8'h0b;
   wire rwrEnd = fallE && nFall == 5'h17 && cmdR == 8'h0c;
   wire holdOn = cmdR == 8'h0c && hc >= 8'h08 && nFall < 5'h18 && !csN;
   wire evEn = |(extEvents & enR);
   // Helper state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sPrev <= 1'b0;
         nFall <= 5'h00;
         cmdR <= 8'h00;
         sh <= 24'h000000;
         enR <= 16'h0000;
         hc <= 8'h00;
         pend <= 1'b0;
         selC <= 8'h00;
      end else begin
         sPrev <= sclk;
         nFall <= csN ? 5'h00 : (fallE ? nFall + 5'h01 : nFall);
         sh <= fallE ? {sh[22:0], din} : sh;
         cmdR <= cmdDone ? cmdNow : (csN ? 8'h00 : cmdR);
         enR <= (fallE && nFall == 5'h17 && cmdR == 8'h8a) ? {sh[14:0], din} : enR;
         hc <= rwrDone ? 8'h00 : (hc == 8'hff ? hc : hc + 8'h01);
         pend <= rwrDone ? 1'b0 : (pend || (holdOn && evEn));
         selC <= !tempSelect ? 8'h00 : (selC == 8'hff ? selC : selC + 8'h01);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);
   sequence s_mhi; modClk [*2]; endsequence
   sequence s_mlo; !modClk [*2]; endsequence
   sequence s_high8; irqN [*8]; endsequence
   property p_rst_idle; $fell(rst) |-> irqN && !tempSelect; endproperty
   property p_ev_irq; csN && evEn |-> ##[1:6] !irqN; endproperty
   property p_release; rwrDone |-> ##[1:7] irqN; endproperty
   property p_hold; holdOn |-> irqN; endproperty
   property p_quiet; rwrEnd && !pend |-> ##1 s_high8; endproperty
   property p_pend; rwrEnd && pend |-> ##[1:8] !irqN; endproperty
   property p_plain; plainDone |-> ##1 ($stable(irqN)) [*8]; endproperty
   property p_modclk; $rose(modClk) |-> s_mhi ##1 s_mlo ##1 modClk; endproperty
   property p_tsel; $fell(tempSelect) |-> selC >= 8'h5c && selC <= 8'h64; endproperty
   property p_temp_irq; $fell(tempSelect) && enR[5] |-> ##[0:4] !irqN; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("active after reset");
   a_ev_irq: assert property (p_ev_irq) else $error("request not raised");
   a_release: assert property (p_release) else $error("request not released");
   a_hold: assert property (p_hold) else $error("request low in transfer");
   a_quiet: assert property (p_quiet) else $error("request low, none pending");
   a_pend: assert property (p_pend) else $error("pending event lost");
   a_plain: assert property (p_plain) else $error("plain read moved request");
   a_modclk: assert property (p_modclk) else $error("modulator clock period");
   a_tsel: assert property (p_tsel) else $error("conversion length");
   a_temp_irq: assert property (p_temp_irq) else $error("no request at end");
endmodule
bind mip_irq_peak_temp mip_sva u_sva (.clk(clk), .rst(rst), .ce(ce), .sclk(sclk),
   .csN(csN), .din(din), .dout(dout), .irqN(irqN), .modBits(modBits), .modClk(modClk),
   .tempSelect(tempSelect), .extEvents(extEvents));
`default_nettype wire

// *** dv/mip_host_model.sv ***
// Purpose: Host controller model on the serial port and request line.
// Assumes: Serial clock idles low and stops between frames.
// Notes: Data line is inverted when released so stale values never match.
`timescale 1ns/10ps
`default_nettype none
module mip_host_model (
   output logic sclk,
   output logic csN,
   output logic din,
   input wire logic dout,
   input wire logic irqN
);
   int irqEdges;
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      din = 1'b0;
      irqEdges = 0;
   end
   // Edge-triggered request input
   always @(negedge irqN) irqEdges++;
   // One frame: command byte then n data bits, MSB first, 160 ns bit time
   task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd,
                       output logic [23:0] rd);
      logic [31:0] sv;
      sv = {cmd, wd << (24 - n)};
      rd = 24'h000000;
      #3 csN = 1'b0;
      for (int i = 0; i < 8 + n; i++) begin
         #40 din = sv[31 - i];
         #40 sclk = 1'b1;
         #80 sclk = 1'b0;
         if (i >= 8) rd = {rd[22:0], dout};
      end
      #40 csN = 1'b1;
      din = ~din;
      // Deselect gap long enough for the core clock to see it
      #40;
   endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the interrupt, peak and temperature block.
// Assumes: Toggling modulator bits give a zero filter word.
// Notes: Register table rows first, then event, peak, conversion, reset cases.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [7:0] cmd;
      logic [5:0] n;
      logic [23:0] wd;
      logic [23:0] want;
   } mip_row_s;
   logic clk, rst, ce, sclk, csN, din, dout, irqN, modClk, tempSelect, tog;
   logic [1:0] modBits, curLvl, volLvl;
   logic [15:0] extEvents;
   int bad_count, num_checks;
   mip_row_s rows [11];
   // Level 2 means alternating bits
   assign modBits = {volLvl[1] ? tog : volLvl[0], curLvl[1] ? tog : curLvl[0]};
   always @(posedge modClk) #1 tog = !tog;
   mip_irq_peak_temp dut (.clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .csN(csN), .din(din),
      .dout(dout), .irqN(irqN), .modBits(modBits), .modClk(modClk),
      .tempSelect(tempSelect), .extEvents(extEvents));
   mip_host_model host (.sclk(sclk), .csN(csN), .din(din), .dout(dout), .irqN(irqN));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic end_sim;
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] want);
      num_checks++;
      if (got !== want) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, want);
      end
   endtask
   task automatic rd(input logic [7:0] cmd, input int n, input logic [23:0] want);
      logic [23:0] v;
      host.xfer(cmd, n, 24'h000000, v);
      chk(v, want);
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic [15:0] ev);
      @(posedge clk);
      #1 extEvents = ev;
      @(posedge clk);
      #1 extEvents = 16'h0000;
   endtask
   // Watchdog
   initial begin
      #800000;
      bad_count++;
      $display("ERROR %0t timeout", $time);
      end_sim();
   end
   initial begin
      logic [23:0] v;
      int e;
      rst = 1'b1;
      ce = 1'b1;
      tog = 1'b0;
      extEvents = 16'h0000;
      curLvl = 2'h2;
      volLvl = 2'h2;
      bad_count = 0;
      num_checks = 0;
      rows = '{'{8'h22, 6'h18, 24'h0, 24'h0}, '{8'h24, 6'h18, 24'h0, 24'h0},
         '{8'h09, 6'h10, 24'h0, 24'h0}, '{8'h0a, 6'h10, 24'h0, 24'h0},
         '{8'h0c, 6'h10, 24'h0, 24'h0}, '{8'h26, 6'h08, 24'h0, 24'h0},
         '{8'h3f, 6'h08, 24'h0, 24'h0}, '{8'h8a, 6'h10, 24'h0000a5, 24'h0},
         '{8'h0a, 6'h10, 24'h0, 24'h0000a5}, '{8'h8b, 6'h10, 24'h00ffff, 24'h0},
         '{8'h0b, 6'h10, 24'h0, 24'h0}};
      cycles(4);
      rst = 1'b0;
      cycles(3);
      // Register table: reset values, enables, read-only and unmapped places
      for (int i = 0; i < 11; i++) begin
         if (rows[i].cmd[7]) host.xfer(rows[i].cmd, int'(rows[i].n), rows[i].wd, v);
         else rd(rows[i].cmd, int'(rows[i].n), rows[i].want);
      end
      // Disabled and enabled events
      pulse(16'h0002);
      cycles(4);
      chk({23'h0, irqN}, 24'h000001);
      pulse(16'h0001);
      cycles(4);
      chk({23'h0, irqN}, 24'h000000);
      rd(8'h0b, 16, 24'h000003);
      e = host.irqEdges;
      rd(8'h0c, 16, 24'h000003);
      cycles(8);
      chk({23'h0, irqN}, 24'h000001);
      rd(8'h0c, 16, 24'h000000);
      // Event arriving during a read with reset
      pulse(16'h0001);
      fork
         rd(8'h0c, 16, 24'h000001);
         begin
            cycles(200);
            pulse(16'h0004);
         end
      join
      cycles(8);
      chk({23'h0, irqN}, 24'h000000);
      chk(24'(host.irqEdges - e), 24'h000002);
      rd(8'h0c, 16, 24'h000004);
      // Peak records
      curLvl = 2'h1;
      volLvl = 2'h1;
      cycles(400);
      rd(8'h22, 24, 24'h400000);
      rd(8'h24, 24, 24'h800000);
      curLvl = 2'h2;
      volLvl = 2'h2;
      cycles(400);
      rd(8'h23, 24, 24'h400000);
      rd(8'h22, 24, 24'h000000);
      rd(8'h25, 24, 24'h800000);
      rd(8'h24, 24, 24'h000000);
      // Temperature conversion at a falling zero crossing
      host.xfer(8'h8a, 16, 24'h000020, v);
      host.xfer(8'h89, 16, 24'h000020, v);
      curLvl = 2'h0;
      volLvl = 2'h1;
      cycles(300);
      volLvl = 2'h0;
      for (e = 0; e < 1000 && tempSelect !== 1'b1; e++) cycles(1);
      chk({23'h0, tempSelect}, 24'h000001);
      for (e = 0; e < 200 && tempSelect !== 1'b0; e++) cycles(1);
      cycles(3);
      chk({23'h0, irqN}, 24'h000000);
      rd(8'h26, 8, 24'h0000c0);
      rd(8'h09, 16, 24'h000000);
      rd(8'h0c, 16, 24'h000020);
      // Clock enable low freezes modulator clock and request
      cycles(1);
      ce = 1'b0;
      v = {22'h000000, modClk, irqN};
      cycles(7);
      chk({22'h000000, modClk, irqN}, v);
      ce = 1'b1;
      // Reset in mid-run with a request pending
      pulse(16'h0020);
      rst = 1'b1;
      cycles(2);
      chk({23'h0, irqN}, 24'h000001);
      rst = 1'b0;
      cycles(3);
      rd(8'h0a, 16, 24'h000000);
      rd(8'h0c, 16, 24'h000000);
      end_sim();
   end
endmodule
`default_nettype wire
